// *** design/pbo_map.svh ***
`ifndef PBO_MAP_SVH
`define PBO_MAP_SVH
// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define PBO_A_TIMER_CTRL   32'hffff8a00
`define PBO_A_SLEEP_CTRL   32'hffff8a04
`define PBO_A_PERIOD_BUF   32'hffff8a08
`define PBO_A_PERIOD_CMP   32'hffff8a0c
`define PBO_A_DEAD_TIME    32'hffff8a10
`define PBO_A_CARRIER_CNT  32'hffff8a14
`define PBO_A_U_BUF_OP     32'hffff8a18
`define PBO_A_U_FREE_OP    32'hffff8a1c
`define PBO_A_U_CMP        32'hffff8a20
`define PBO_A_V_BUF_OP     32'hffff8a28
`define PBO_A_V_FREE_OP    32'hffff8a2c
`define PBO_A_V_CMP        32'hffff8a30
`define PBO_A_W_BUF_OP     32'hffff8a38
`define PBO_A_W_FREE_OP    32'hffff8a3c
`define PBO_A_W_CMP        32'hffff8a40
`define PBO_A_OD_CTRL      32'hffff8a50
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PBO_B_COUNT_RUN    0
`define PBO_B_SLEEP_BIT    0
`define PBO_B_IRQ_EN       8
`define PBO_B_FLAG_LO      12
`define PBO_B_RSVD_TOP     15
// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define PBO_RST_PERIOD     16'hffff
`define PBO_RST_DEAD       16'h0000
`define PBO_RST_DUTY       16'h0000
`define PBO_LOW_SAMPLES    5'h10
`define PBO_DIV_A          8
`define PBO_DIV_B          16
`define PBO_DIV_C          128
`endif

// *** design/pbo_pkg.sv ***
package pbo_pkg;
  // Input mode of one disable request
  typedef enum logic [1:0] {
    PBO_FALL     = 2'h0,
    PBO_LOW_DIV8 = 2'h1,
    PBO_LOW_D16  = 2'h2,
    PBO_LOW_D128 = 2'h3
  } pbo_mode_t;
  typedef logic [15:0] pbo_word_t;
endpackage

// *** design/pbo_req_filter.sv ***
`timescale 1ns/1ps
`include "pbo_map.svh"
module pbo_req_filter
  import pbo_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst,
  input  wire logic      req_n,
  input  wire pbo_mode_t mode,
  input  wire logic      en_div8,
  input  wire logic      en_div16,
  input  wire logic      en_div128,
  output logic           hit
);
  logic       sync1;
  logic       sync2;
  logic       prev;
  logic [4:0] low_cnt;
  logic [4:0] next_low_cnt;
  logic       sample_en;

  // ----------------------------------------------------------
  // Sampling and counting
  // ----------------------------------------------------------
  // Sample enable picked by mode; high sample restarts the run
  always_comb begin
    case (mode)
      PBO_LOW_DIV8: sample_en = en_div8;
      PBO_LOW_D16:  sample_en = en_div16;
      PBO_LOW_D128: sample_en = en_div128;
      default:      sample_en = 1'b0;
    endcase
    next_low_cnt = low_cnt;
    if (mode == PBO_FALL) begin
      next_low_cnt = 5'h0;
    end else if (sample_en) begin
      if (sync2) begin
        next_low_cnt = 5'h0;
      end else if (low_cnt != `PBO_LOW_SAMPLES) begin
        next_low_cnt = low_cnt + 5'h1;
      end
    end
    // Level mode keeps requesting while the pin stays low
    if (mode == PBO_FALL) begin
      hit = prev & ~sync2;
    end else begin
      hit = sample_en & ~sync2 &
            (low_cnt >= (`PBO_LOW_SAMPLES - 5'h1));
    end
  end

  // Two-stage synchroniser, first stage read only by second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1   <= 1'b1;
      sync2   <= 1'b1;
      prev    <= 1'b1;
      low_cnt <= 5'h0;
    end else begin
      sync1   <= req_n;
      sync2   <= sync1;
      prev    <= sync2;
      low_cnt <= next_low_cnt;
    end
  end
endmodule

// *** design/pbo_top.sv ***
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pbo_map.svh"
// What this block does
// - Timer starts in module standby; its registers open once released.
// - Buffer write meeting a compare match transfers the new value.
// - Compare write meeting a compare match is dropped; buffer loads instead.
// - Such a write may drop one phase pair pulse for one carrier cycle.
// - Free-op duty addresses decoded at their three fixed addresses.
// - Dead time is not changed after start; writes still load it while count run is set; its counter is not writable.
// - Halting the carrier may shorten dead time; keep count run set.
// - Restart two: standby reinitialises timer state, then release and run.
// - Three requests force six outputs to high impedance, maybe interrupt.
// - Outputs also float in standby mode or when oscillator stops.
// - Each request: falling edge or sixteen low samples at clk/8,16,128.
// - Output-disable control/status register: 16 bits, read and write.
// - Bit 15 of that register reads as zero.
// - Third flag bit 14 sets on event; cleared by zero after reading one.
// - Interrupt may be raised on a detected input condition.
// - Mode field: 00 edge, 01/10/11 low samples at /8, /16, /128.
// - Enable bit 8 gates interrupt from any set request flag.
// - Any one request condition floats all timer outputs.
module pbo_top
  import pbo_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        disable_request_in_1_n,
  input  wire logic        disable_request_in_2_n,
  input  wire logic        disable_request_in_3_n,
  input  wire logic        standby_mode,
  input  wire logic        osc_stop,
  output logic [5:0]       phase_out,
  output logic [5:0]       phase_out_oe,
  output logic             disable_irq
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  logic            timer_sleep_bit, next_timer_sleep_bit;
  logic            count_run, next_count_run;
  pbo_word_t       period_buffer, next_period_buffer;
  pbo_word_t       period_compare, next_period_compare;
  pbo_word_t       dead_time_setting, next_dead_time_setting;
  pbo_word_t       duty_buffer [3], next_duty_buffer [3];
  pbo_word_t       phase_compare [3], next_phase_compare [3];
  pbo_word_t       carrier_counter, next_carrier_counter;
  logic            count_up, next_count_up;
  logic [5:0]      od_mode, next_od_mode;
  logic            irq_en, next_irq_en;
  logic [2:0]      req_flag, next_req_flag;
  logic [2:0]      flag_seen, next_flag_seen;
  logic            bvalid, next_bvalid;
  logic [1:0]      bresp, next_bresp;
  logic            rvalid, next_rvalid;
  logic [1:0]      rresp, next_rresp;
  logic [31:0]     rdata, next_rdata;
  logic [6:0]      div_cnt;
  logic [2:0]      req_hit;
  logic            wr_go, rd_go, timer_on, match, hiz;
  logic [15:0]     wval, od_word;
  logic [16:0]     cnt_floor;
  logic [2:0]      req_n;

  assign timer_on  = timer_sleep_bit;       // 1 = out of module standby
  assign wr_go     = s_axi_awvalid & s_axi_wvalid & ~bvalid;
  assign rd_go     = s_axi_arvalid & ~rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;
  assign cnt_floor = {dead_time_setting, 1'b0};
  // Compare-match event that drives buffer transfer: carrier peak
  assign match = timer_on & count_run & count_up &
                 ({1'b0, carrier_counter} >= {1'b0, period_compare});
  // Byte-lane merge of the low 16 bits only
  assign wval = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00,
                 s_axi_wstrb[0] ? s_axi_wdata[7:0]  : 8'h00};
  assign od_word = {1'b0, req_flag, 3'h0, irq_en, 2'h0, od_mode};
  assign req_n = {disable_request_in_3_n, disable_request_in_2_n,
                  disable_request_in_1_n};

  // ----------------------------------------------------------
  // Sample clock divider and request filters
  // ----------------------------------------------------------
  // Free-running divider; pulses are shared by all three inputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt <= 7'h0;
    end else begin
      div_cnt <= div_cnt + 7'h1;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_req
    pbo_req_filter u_filt (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .req_n     (req_n[g]),
      .mode      (pbo_mode_t'(od_mode[2*g +: 2])),
      .en_div8   (div_cnt[2:0] == 3'h7),
      .en_div16  (div_cnt[3:0] == 4'hf),
      .en_div128 (div_cnt == 7'h7f),
      .hit       (req_hit[g])
    );
  end

  // ----------------------------------------------------------
  // Register file, carrier counter and bus answers
  // ----------------------------------------------------------
  always_comb begin
    next_timer_sleep_bit   = timer_sleep_bit;
    next_count_run         = count_run;
    next_period_buffer     = period_buffer;
    next_period_compare    = period_compare;
    next_dead_time_setting = dead_time_setting;
    next_duty_buffer       = duty_buffer;
    next_phase_compare     = phase_compare;
    next_od_mode           = od_mode;
    next_irq_en            = irq_en;
    next_flag_seen         = flag_seen;
    next_carrier_counter   = carrier_counter;
    next_count_up          = count_up;
    next_bvalid = bvalid & ~s_axi_bready;
    next_bresp  = bresp;
    next_rvalid = rvalid & ~s_axi_rready;
    next_rresp  = rresp;
    next_rdata  = rdata;
    // Triangle carrier between twice the dead time and the period
    if (timer_on && count_run) begin
      if (count_up) begin
        if (match) begin
          next_count_up = 1'b0;
        end else begin
          next_carrier_counter = carrier_counter + 16'h1;
        end
      end else if ({1'b0, carrier_counter} <= cnt_floor) begin
        next_count_up = 1'b1;
      end else begin
        next_carrier_counter = carrier_counter - 16'h1;
      end
    end
    // Buffer transfer on match; writes below may override it
    if (match) begin
      next_period_compare = period_buffer;
      for (int i = 0; i < 3; i++) begin
        next_phase_compare[i] = duty_buffer[i];
      end
    end
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp  = 2'h0;
      case (s_axi_awaddr)
        `PBO_A_SLEEP_CTRL: next_timer_sleep_bit = wval[`PBO_B_SLEEP_BIT];
        `PBO_A_OD_CTRL: begin
          next_od_mode   = wval[5:0];
          next_irq_en    = wval[`PBO_B_IRQ_EN];
          next_flag_seen = 3'h0;
        end
        default: begin
          if (!timer_on) begin
            next_bresp = 2'h0;
          end else begin
            case (s_axi_awaddr)
              `PBO_A_TIMER_CTRL: next_count_run = wval[`PBO_B_COUNT_RUN];
              `PBO_A_PERIOD_BUF: begin
                next_period_buffer = wval;
                if (match) next_period_compare = wval;
              end
              `PBO_A_PERIOD_CMP: begin
                if (!match) next_period_compare = wval;
              end
              `PBO_A_DEAD_TIME: next_dead_time_setting = wval;
              `PBO_A_U_BUF_OP, `PBO_A_V_BUF_OP, `PBO_A_W_BUF_OP: begin
                for (int i = 0; i < 3; i++) begin
                  if (s_axi_awaddr[5:4] == 2'(i + 1)) begin
                    next_duty_buffer[i] = wval;
                    if (match) next_phase_compare[i] = wval;
                  end
                end
              end
              `PBO_A_U_FREE_OP, `PBO_A_V_FREE_OP, `PBO_A_W_FREE_OP: begin
                // Immediate compare load; old+dead time may lose a pulse
                for (int i = 0; i < 3; i++) begin
                  if (s_axi_awaddr[5:4] == 2'(i + 1)) begin
                    next_duty_buffer[i]   = wval;
                    next_phase_compare[i] = wval;
                  end
                end
              end
              `PBO_A_U_CMP, `PBO_A_V_CMP, `PBO_A_W_CMP: begin
                for (int i = 0; i < 3; i++) begin
                  if (s_axi_awaddr[5:4] == 2'(i + 2) && !match) begin
                    next_phase_compare[i] = wval;
                  end
                end
              end
              `PBO_A_CARRIER_CNT: next_bresp = 2'h0;
              default: next_bresp = 2'h2;
            endcase
          end
        end
      endcase
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'h0;
      next_rdata  = 32'h0;
      case (s_axi_araddr)
        `PBO_A_SLEEP_CTRL: next_rdata = {31'h0, timer_sleep_bit};
        `PBO_A_OD_CTRL: begin
          next_rdata     = {16'h0, od_word};
          next_flag_seen = req_flag;
        end
        `PBO_A_TIMER_CTRL: next_rdata = {31'h0, count_run & timer_on};
        `PBO_A_PERIOD_BUF: next_rdata = {16'h0, period_buffer};
        `PBO_A_PERIOD_CMP: next_rdata = {16'h0, period_compare};
        `PBO_A_DEAD_TIME:  next_rdata = {16'h0, dead_time_setting};
        `PBO_A_CARRIER_CNT: next_rdata = {16'h0, carrier_counter};
        `PBO_A_U_BUF_OP, `PBO_A_U_FREE_OP:
          next_rdata = {16'h0, duty_buffer[0]};
        `PBO_A_V_BUF_OP, `PBO_A_V_FREE_OP:
          next_rdata = {16'h0, duty_buffer[1]};
        `PBO_A_W_BUF_OP, `PBO_A_W_FREE_OP:
          next_rdata = {16'h0, duty_buffer[2]};
        `PBO_A_U_CMP: next_rdata = {16'h0, phase_compare[0]};
        `PBO_A_V_CMP: next_rdata = {16'h0, phase_compare[1]};
        `PBO_A_W_CMP: next_rdata = {16'h0, phase_compare[2]};
        default: next_rresp = 2'h2;
      endcase
      // Timer registers read as zero while in module standby
      if (!timer_on && s_axi_araddr != `PBO_A_SLEEP_CTRL &&
          s_axi_araddr != `PBO_A_OD_CTRL) begin
        next_rdata = 32'h0;
      end
    end
    // Standby wipes internal timer state for the second restart
    if (!timer_on) begin
      next_count_run       = 1'b0;
      next_carrier_counter = dead_time_setting <<< 1;
      next_count_up        = 1'b1;
    end else if (!count_run) begin
      next_carrier_counter = 16'({dead_time_setting, 1'b0});
      next_count_up        = 1'b1;
    end
  end

  // Request flags: a new event wins over a clear in the same cycle
  always_comb begin
    next_req_flag = req_flag;
    for (int i = 0; i < 3; i++) begin
      if (wr_go && s_axi_awaddr == `PBO_A_OD_CTRL && flag_seen[i] &&
          !wval[`PBO_B_FLAG_LO + i]) begin
        next_req_flag[i] = 1'b0;
      end
      if (req_hit[i]) begin
        next_req_flag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer_sleep_bit   <= 1'b0;
      count_run         <= 1'b0;
      period_buffer     <= `PBO_RST_PERIOD;
      period_compare    <= `PBO_RST_PERIOD;
      dead_time_setting <= `PBO_RST_DEAD;
      for (int i = 0; i < 3; i++) begin
        duty_buffer[i]   <= `PBO_RST_DUTY;
        phase_compare[i] <= `PBO_RST_DUTY;
      end
      carrier_counter   <= 16'h0;
      count_up          <= 1'b1;
      od_mode           <= 6'h0;
      irq_en            <= 1'b0;
      req_flag          <= 3'h0;
      flag_seen         <= 3'h0;
      bvalid            <= 1'b0;
      bresp             <= 2'h0;
      rvalid            <= 1'b0;
      rresp             <= 2'h0;
      rdata             <= 32'h0;
    end else begin
      timer_sleep_bit   <= next_timer_sleep_bit;
      count_run         <= next_count_run;
      period_buffer     <= next_period_buffer;
      period_compare    <= next_period_compare;
      dead_time_setting <= next_dead_time_setting;
      duty_buffer       <= next_duty_buffer;
      phase_compare     <= next_phase_compare;
      carrier_counter   <= next_carrier_counter;
      count_up          <= next_count_up;
      od_mode           <= next_od_mode;
      irq_en            <= next_irq_en;
      req_flag          <= next_req_flag;
      flag_seen         <= next_flag_seen;
      bvalid            <= next_bvalid;
      bresp             <= next_bresp;
      rvalid            <= next_rvalid;
      rresp             <= next_rresp;
      rdata             <= next_rdata;
    end
  end

  // ----------------------------------------------------------
  // Phase outputs with dead time and output disable
  // ----------------------------------------------------------
  assign hiz = standby_mode | osc_stop | (|req_flag) | ~timer_on;
  assign disable_irq = irq_en & (|req_flag);

  for (genvar g = 0; g < 3; g++) begin : g_phase
    logic      hi, prev_hi, busy;
    pbo_word_t dt_cnt, next_dt_cnt;
    logic [1:0] pair, next_pair;
    assign hi   = carrier_counter >= phase_compare[g];
    assign busy = dt_cnt != 16'h0;
    // Dead-time counter runs from each edge and cannot be loaded
    always_comb begin
      next_dt_cnt = dt_cnt;
      if (hi != prev_hi) begin
        next_dt_cnt = 16'h1;
      end else if (busy) begin
        next_dt_cnt = (dt_cnt >= dead_time_setting) ? 16'h0
                                                    : dt_cnt + 16'h1;
      end
      next_pair = {~hi & ~busy, hi & ~busy};
    end
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        prev_hi <= 1'b0;
        dt_cnt  <= 16'h0;
        pair    <= 2'h0;
      end else begin
        prev_hi <= hi;
        dt_cnt  <= next_dt_cnt;
        pair    <= next_pair;
      end
    end
    assign phase_out[2*g +: 2]    = pair;
    assign phase_out_oe[2*g +: 2] = {2{~hiz}};
  end
endmodule

// *** verif/pbo_top_properties.sv ***
`timescale 1ns/1ps
module pbo_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        standby_mode,
  input wire logic        osc_stop,
  input wire logic [5:0]  phase_out_oe,
  input wire logic        disable_irq
);
  // ------------------------------------------------------------
  // One clock domain, reset disables every check
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_STBY_FLOAT: assert property ((standby_mode || osc_stop) |->
    phase_out_oe == 6'h00) else $error("outputs driven in standby");
  AST_IRQ_FLOAT: assert property (disable_irq |->
    phase_out_oe == 6'h00) else $error("irq without float");
  AST_OE_ALL: assert property (phase_out_oe == 6'h00 ||
    phase_out_oe == 6'h3f) else $error("outputs float apart");
  AST_RST_STBY: assert property ($past(rst) |->
    phase_out_oe == 6'h00) else $error("outputs driven after reset");
  AST_WR_ANS: assert property ((s_axi_awvalid && s_axi_wvalid &&
    !s_axi_bvalid) |=> s_axi_bvalid) else $error("late write answer");
  AST_RD_ANS: assert property ((s_axi_arvalid && !s_axi_rvalid)
    |=> s_axi_rvalid) else $error("late read answer");
  AST_B_DROP: assert property ((s_axi_bvalid && s_axi_bready)
    |=> !s_axi_bvalid) else $error("write answer repeated");
  AST_R_DROP: assert property ((s_axi_rvalid && s_axi_rready)
    |=> !s_axi_rvalid) else $error("read answer repeated");
  AST_RD_TOP: assert property (s_axi_rvalid |->
    s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
endmodule

bind pbo_top pbo_chk pbo_chk_inst (.clk_sys(clk_sys), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .standby_mode(standby_mode), .osc_stop(osc_stop),
  .phase_out_oe(phase_out_oe), .disable_irq(disable_irq));

// *** verif/pbo_fault_src.sv ***
`timescale 1ns/1ps
module pbo_fault_src (
  input wire logic        clk_sys,
  input wire logic [2:0]  pull_low,
  input wire logic [5:0]  phase_out,
  input wire logic [5:0]  phase_out_oe,
  output logic [2:0]      req_n,
  output logic [5:0]      gate_line
);
  // Fault lines idle high; a source pulls its line low
  initial req_n = 3'h7;
  always @(posedge clk_sys) req_n <= ~pull_low;
  // Gate drivers see a pull-down once the pins float
  assign gate_line = phase_out & phase_out_oe;
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "pbo_map.svh"
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic [31:0] rdata;
  logic        aw_v = 1'b0;
  logic        w_v = 1'b0;
  logic        ar_v = 1'b0;
  logic        aw_r, w_r, ar_r, b_v, r_v, irq;
  logic [1:0]  bresp, rresp;
  logic        stby = 1'b0;
  logic        osc = 1'b0;
  logic [2:0]  pull_low = 3'h0;
  logic [2:0]  req_n;
  logic [5:0]  pout, oe, gate;
  logic [31:0] ie;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          d;

  initial forever #20 clk_sys = ~clk_sys;

  pbo_top pbo_top_inst (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(bresp), .s_axi_bvalid(b_v),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(r_v), .s_axi_rready(1'b1),
    .disable_request_in_1_n(req_n[0]), .disable_request_in_2_n(req_n[1]),
    .disable_request_in_3_n(req_n[2]), .standby_mode(stby),
    .osc_stop(osc), .phase_out(pout), .phase_out_oe(oe),
    .disable_irq(irq));
  pbo_fault_src pbo_fault_src_inst (.clk_sys(clk_sys),
    .pull_low(pull_low), .phase_out(pout), .phase_out_oe(oe),
    .req_n(req_n), .gate_line(gate));

  // ------------------------------------------------------------
  // Compare, bus and closing tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Address and data offered together, released once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] dt);
    aw_v <= 1'b1;
    w_v <= 1'b1;
    awaddr <= a;
    wdata <= dt;
    do @(posedge clk_sys); while (!(aw_r && w_r));
    aw_v <= 1'b0;
    w_v <= 1'b0;
    do @(posedge clk_sys); while (!b_v);
    chk({30'h0, bresp}, 32'h0);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                    input logic [1:0] er = 2'h0);
    ar_v <= 1'b1;
    araddr <= a;
    do @(posedge clk_sys); while (!ar_r);
    ar_v <= 1'b0;
    do @(posedge clk_sys); while (!r_v);
    chk({30'h0, rresp}, {30'h0, er});
    chk(rdata, exp);
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, well above the longest level-mode run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude;
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({26'h0, oe}, 32'h0);
    rd(`PBO_A_PERIOD_CMP, 32'h0);
    wr(`PBO_A_SLEEP_CTRL, 32'h1);
    rd(`PBO_A_PERIOD_CMP, 32'hffff);
    wr(`PBO_A_TIMER_CTRL, 32'h1);
    rd(32'hffff8a44, 32'h0, 2'h2);
    // Free-op writes land in the compare at once
    for (int g = 0; g < 3; g++) begin
      wr(`PBO_A_U_FREE_OP + 32'h10 * g, 32'h100 + g);
      rd(`PBO_A_U_CMP + 32'h10 * g, 32'h100 + g);
    end
    chk({26'h0, oe}, 32'h3f);
    wr(`PBO_A_OD_CTRL, 32'hffff);
    rd(`PBO_A_OD_CTRL, 32'h013f);
    // Edge mode per input; clearing needs a read of one first
    for (int i = 0; i < 3; i++) begin
      ie = (i != 1) ? 32'h100 : 32'h0;
      wr(`PBO_A_OD_CTRL, ie);
      pull_low <= 3'h1 << i;
      @(posedge clk_sys);
      pull_low <= 3'h0;
      repeat (6) @(posedge clk_sys);
      chk({26'h0, oe}, 32'h0);
      chk({31'h0, irq}, ie >> 8);
      wr(`PBO_A_OD_CTRL, ie);
      rd(`PBO_A_OD_CTRL, ie | (32'h1000 << i));
      wr(`PBO_A_OD_CTRL, ie);
      rd(`PBO_A_OD_CTRL, ie);
      chk({25'h0, irq, oe}, 32'h3f);
    end
    // Level modes: a high sample restarts the count
    for (int m = 1; m < 4; m++) begin
      d = (m == 1) ? 8 : (m == 2) ? 16 : 128;
      wr(`PBO_A_OD_CTRL, m << 4);
      pull_low <= 3'h4;
      repeat (12 * d) @(posedge clk_sys);
      pull_low <= 3'h0;
      repeat (2 * d) @(posedge clk_sys);
      pull_low <= 3'h4;
      repeat (12 * d) @(posedge clk_sys);
      chk({26'h0, oe}, 32'h3f);
      repeat (6 * d) @(posedge clk_sys);
      chk({26'h0, oe}, 32'h0);
      pull_low <= 3'h0;
      repeat (2 * d + 4) @(posedge clk_sys);
      rd(`PBO_A_OD_CTRL, 32'h4000 | (m << 4));
      wr(`PBO_A_OD_CTRL, m << 4);
      rd(`PBO_A_OD_CTRL, m << 4);
    end
    // Standby and a stopped oscillator both float the pins
    for (int k = 0; k < 2; k++) begin
      stby <= (k == 0);
      osc <= (k == 1);
      repeat (2) @(posedge clk_sys);
      chk({20'h0, gate, oe}, 32'h0);
    end
    stby <= 1'b0;
    osc <= 1'b0;
    // First restart: zero duties, wait, halt, then run again
    for (int g = 0; g < 3; g++) begin
      wr(`PBO_A_U_FREE_OP + 32'h10 * g, 32'h0);
    end
    repeat (2) @(posedge clk_sys);
    wr(`PBO_A_TIMER_CTRL, 32'h0);
    // Period one makes a match every fourth cycle once running
    wr(`PBO_A_PERIOD_BUF, 32'h1);
    wr(`PBO_A_PERIOD_CMP, 32'h1);
    wr(`PBO_A_U_BUF_OP, 32'h20);
    rd(`PBO_A_U_CMP, 32'h0);
    wr(`PBO_A_TIMER_CTRL, 32'h1);
    // These two writes are taken in the match cycle
    wr(`PBO_A_U_CMP, 32'h30);
    rd(`PBO_A_U_CMP, 32'h20);
    wr(`PBO_A_U_BUF_OP, 32'h50);
    rd(`PBO_A_U_CMP, 32'h50);
    // Second restart: standby clears count run and the carrier; compares are kept
    wr(`PBO_A_TIMER_CTRL, 32'h0);
    wr(`PBO_A_SLEEP_CTRL, 32'h0);
    wr(`PBO_A_SLEEP_CTRL, 32'h1);
    rd(`PBO_A_U_CMP, 32'h50);
    rd(`PBO_A_CARRIER_CNT, 32'h0);
    // Carrier at zero: u below its compare, v and w at or above
    repeat (4) @(posedge clk_sys);
    chk({26'h0, gate}, 32'h16);
    conclude;
  end
endmodule
